// File: rtl/alu_consts.svh
`ifndef ALU_CONSTS_SVH
`define ALU_CONSTS_SVH

// accumulator and memory word widths
`define ALU_ACC_W 32
`define ALU_WORD_W 16
// accumulator stack depth
`define ALU_STACK_DEPTH 8
// octal operand: six digits, one per nibble
`define ALU_OCT_DIGITS 6
`define ALU_OCT_W 24
// bit count operand width and limits
`define ALU_CNT_W 6
`define ALU_CNT_MIN 1
`define ALU_CNT_MAX 32
// reset values
`define ALU_ACC_RST 32'h0000_0000
`define ALU_ADDR_RST 16'h0000

`endif

// File: rtl/alu_pkg.sv
package alu_pkg;
  `include "alu_consts.svh"

  // load instruction selector
  typedef enum logic [1:0] {
    OP_FMT_BITS = 2'b00, // formatted_bit_load
    OP_OCT_ADDR = 2'b01, // octal_address_load
    OP_IDX_WORD = 2'b10, // indexed_word_load
    OP_TBL_CONST = 2'b11 // constant_table_indexed_load
  } alu_op_t;

  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_REQ = 2'b01,
    ST_WAIT = 2'b10
  } alu_state_t;

  typedef logic [`ALU_ACC_W-1:0] alu_word_t;
endpackage

// File: rtl/alu_stack_if.sv
`timescale 1ns/1ns
interface alu_stack_if;
  import alu_pkg::*;
  logic push;
  alu_word_t push_data;
  alu_word_t top;

  modport unit (output push, output push_data, input top);
  modport stack (input push, input push_data, output top);
endinterface

// File: rtl/alu_acc_stack.sv
`timescale 1ns/1ns
`include "alu_consts.svh"
module alu_acc_stack
  import alu_pkg::*;
#(
  parameter int DEPTH = `ALU_STACK_DEPTH
) (
  input wire logic clock_i,
  input wire logic arst_n_i,
  alu_stack_if.stack st
);
  alu_word_t entry_r [DEPTH];

  // push shifts every level down, the last level falls off
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      for (int i = 0; i < DEPTH; i++)
        entry_r[i] <= `ALU_ACC_RST;
    end
    else if (st.push)
    begin
      entry_r[0] <= st.push_data;
      for (int i = 1; i < DEPTH; i++)
        entry_r[i] <= entry_r[i-1];
    end
  end

  // top is read in place, order untouched
  assign st.top = entry_r[0];

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_stack_shift_down: assert property (
    st.push |=> entry_r[DEPTH-1] == $past(entry_r[DEPTH-2])
      && entry_r[0] == $past(st.push_data))
    else $error("stack did not shift on push");
  a_top_read_keeps: assert property (
    !st.push |=> $stable(entry_r[0]) && $stable(entry_r[DEPTH-1]))
    else $error("stack changed without push");
  c_stack_deep_push: cover property (st.push [*8]);
endmodule

// File: rtl/alu_load_unit.sv
// How it works
// - formatted bit load gathers 1 to 32 consecutive bits from start bit.
// - after formatted bit load, bits above the count read zero.
// - zero flag set when loaded value is zero, cleared otherwise.
// - unconsumed accumulator value is pushed onto stack before a new load.
// - octal address load converts octal operand to binary, 16-bit result.
// - indexed word load takes stack top as plain binary offset.
// - indexed word load reads word at base plus offset into low half.
// - indexed word load clears the upper 16 accumulator bits.
// - table load uses stack top to select constant in data label area.
// - table load offset is binary; constant goes into low half.
// - stack holds eight 32-bit entries, push shifts down, eighth lost.
`timescale 1ns/1ns
`include "alu_consts.svh"
module alu_load_unit
  import alu_pkg::*;
(
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic instr_valid_i,
  input wire alu_op_t instr_op_i,
  input wire logic [`ALU_OCT_W-1:0] operand_i,
  input wire logic [`ALU_CNT_W-1:0] bit_count_i,
  input wire logic out_consumed_i,
  input wire logic mem_ack_i,
  input wire logic [`ALU_ACC_W-1:0] mem_rdata_i,
  output logic mem_req_o,
  output alu_op_t mem_kind_o,
  output logic [`ALU_WORD_W-1:0] mem_addr_o,
  output logic [`ALU_WORD_W-1:0] mem_index_o,
  output logic [`ALU_ACC_W-1:0] acc_o,
  output logic zero_result_flag_o,
  output logic busy_o,
  output logic done_o
);
  // mask of the low n bits, n of 32 or more gives all ones
  function automatic alu_word_t fmt_mask(input logic [`ALU_CNT_W-1:0] n);
    logic [`ALU_ACC_W:0] m;
    m = ({{`ALU_ACC_W{1'b0}}, 1'b1} << n) - {{`ALU_ACC_W{1'b0}}, 1'b1};
    return m[`ALU_ACC_W-1:0];
  endfunction

  // octal digits held one per nibble, packed three bits each
  function automatic logic [`ALU_WORD_W-1:0] oct_to_bin(
    input logic [`ALU_OCT_W-1:0] d);
    logic [3*`ALU_OCT_DIGITS-1:0] b;
    b = '0;
    for (int i = 0; i < `ALU_OCT_DIGITS; i++)
      b[3*i +: 3] = d[4*i +: 3];
    return b[`ALU_WORD_W-1:0];
  endfunction

  // low half loaded, upper half cleared
  function automatic alu_word_t low_half(input alu_word_t w);
    return {{(`ALU_ACC_W-`ALU_WORD_W){1'b0}}, w[`ALU_WORD_W-1:0]};
  endfunction

  alu_stack_if stk ();

  alu_acc_stack #(
    .DEPTH(`ALU_STACK_DEPTH)
  ) u_stack (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .st(stk.stack)
  );

  alu_state_t state_r;
  alu_op_t op_r;
  logic [`ALU_WORD_W-1:0] arg_r;
  logic [`ALU_CNT_W-1:0] cnt_r;
  alu_word_t acc_r;
  alu_word_t load_nxt;
  logic pending_r;
  logic zero_r;
  logic done_r;
  logic req_r;
  logic busy_r;
  logic [`ALU_WORD_W-1:0] addr_r;
  logic [`ALU_WORD_W-1:0] index_r;
  logic accept;
  logic finish;
  logic [`ALU_WORD_W-1:0] offset;

  assign accept = instr_valid_i && state_r == ST_IDLE;
  assign finish = state_r == ST_WAIT && mem_ack_i;
  // stack top taken as plain binary, never octal
  assign offset = stk.top[`ALU_WORD_W-1:0];

  // previous unconsumed value goes on the stack
  assign stk.push = accept && pending_r;
  assign stk.push_data = acc_r;

  // value that the finishing load places in the accumulator
  always_comb
  begin
    unique case (op_r)
      OP_FMT_BITS: load_nxt = mem_rdata_i & fmt_mask(cnt_r);
      OP_IDX_WORD: load_nxt = low_half(mem_rdata_i);
      OP_TBL_CONST: load_nxt = low_half(mem_rdata_i);
      OP_OCT_ADDR: load_nxt = low_half(mem_rdata_i);
    endcase
  end

  // sequencer, busy flop follows the next state
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_r <= ST_IDLE;
      busy_r <= 1'b0;
    end
    else
    begin
      unique case (state_r)
        ST_IDLE:
          if (accept && instr_op_i != OP_OCT_ADDR)
          begin
            state_r <= ST_REQ;
            busy_r <= 1'b1;
          end
        ST_REQ: state_r <= ST_WAIT;
        ST_WAIT:
          if (mem_ack_i)
          begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
          end
        default:
        begin
          state_r <= ST_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // instruction fields captured when taken
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      op_r <= OP_FMT_BITS;
      arg_r <= `ALU_ADDR_RST;
      cnt_r <= '0;
    end
    else if (accept)
    begin
      op_r <= instr_op_i;
      arg_r <= operand_i[`ALU_WORD_W-1:0];
      cnt_r <= bit_count_i;
    end
  end

  // memory request, address formed after the push settles
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      req_r <= 1'b0;
      addr_r <= `ALU_ADDR_RST;
      index_r <= `ALU_ADDR_RST;
    end
    else if (state_r == ST_REQ)
    begin
      req_r <= 1'b1;
      index_r <= `ALU_ADDR_RST;
      unique case (op_r)
        OP_IDX_WORD: addr_r <= 16'(arg_r + offset);
        OP_TBL_CONST:
        begin
          addr_r <= arg_r;
          index_r <= offset;
        end
        default: addr_r <= arg_r;
      endcase
    end
    else if (finish)
      req_r <= 1'b0;
  end

  // accumulator and zero flag
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      acc_r <= `ALU_ACC_RST;
      zero_r <= 1'b0;
    end
    else if (accept && instr_op_i == OP_OCT_ADDR)
    begin
      acc_r <= low_half({16'h0000, oct_to_bin(operand_i)});
      zero_r <= oct_to_bin(operand_i) == '0;
    end
    else if (finish)
    begin
      acc_r <= load_nxt;
      zero_r <= load_nxt == '0;
    end
  end

  // unconsumed marker, a finishing load wins over consumption
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      pending_r <= 1'b0;
    else if (finish || (accept && instr_op_i == OP_OCT_ADDR))
      pending_r <= 1'b1;
    else if (out_consumed_i)
      pending_r <= 1'b0;
  end

  // completion pulse
  always_ff @(posedge clock_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
      done_r <= 1'b0;
    else
      done_r <= finish || (accept && instr_op_i == OP_OCT_ADDR);
  end

  assign mem_req_o = req_r;
  assign mem_kind_o = op_r;
  assign mem_addr_o = addr_r;
  assign mem_index_o = index_r;
  assign acc_o = acc_r;
  assign zero_result_flag_o = zero_r;
  assign busy_o = busy_r;
  assign done_o = done_r;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  a_zero_flag_match: assert property (
    done_r |-> zero_result_flag_o == (acc_o == '0))
    else $error("zero flag disagrees with accumulator");
  a_fmt_bits_load: assert property (
    finish && op_r == OP_FMT_BITS
      |=> acc_o == ($past(mem_rdata_i) & fmt_mask($past(cnt_r))))
    else $error("formatted bits not loaded");
  a_fmt_upper_clear: assert property (
    done_r && op_r == OP_FMT_BITS && cnt_r < 6'h20
      |-> (acc_o >> cnt_r) == '0)
    else $error("bits above count not cleared");
  a_push_on_pending: assert property (
    accept && pending_r |=> stk.top == $past(acc_r))
    else $error("pending value not pushed");
  a_oct_convert: assert property (
    accept && instr_op_i == OP_OCT_ADDR
      |=> acc_o == low_half({16'h0000, oct_to_bin($past(operand_i))})
        && done_o)
    else $error("octal conversion wrong");
  a_idx_sum_addr: assert property (
    state_r == ST_REQ && op_r == OP_IDX_WORD
      |=> mem_req_o && mem_addr_o == $past(arg_r) + $past(offset))
    else $error("indexed address not base plus offset");
  a_idx_upper_clear: assert property (
    finish && op_r == OP_IDX_WORD
      |=> acc_o[31:16] == 16'h0000
        && acc_o[15:0] == $past(mem_rdata_i[15:0]))
    else $error("indexed load upper half not cleared");
  a_tbl_index_sel: assert property (
    state_r == ST_REQ && op_r == OP_TBL_CONST
      |=> mem_index_o == $past(offset) && mem_addr_o == $past(arg_r))
    else $error("table index not taken from stack top");
  a_tbl_low_half: assert property (
    finish && op_r == OP_TBL_CONST |=> acc_o[31:16] == 16'h0000)
    else $error("table load upper half not cleared");
  a_req_timing: assert property (
    accept && instr_op_i != OP_OCT_ADDR |=> ##1 mem_req_o)
    else $error("memory request late");

  c_fmt_done: cover property (done_r && op_r == OP_FMT_BITS);
  c_idx_done: cover property (done_r && op_r == OP_IDX_WORD);
  c_tbl_done: cover property (done_r && op_r == OP_TBL_CONST);
  c_push_load: cover property (accept && pending_r);
endmodule

// File: tb/alu_load_unit_tb.sv
`timescale 1ns/1ns
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module alu_load_unit_tb
  import alu_pkg::*;
;
  logic clock_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic instr_valid_i = 1'b0;
  alu_op_t instr_op_i = OP_FMT_BITS;
  logic [23:0] operand_i = 24'h000000;
  logic [5:0] bit_count_i = 6'h00;
  logic out_consumed_i = 1'b0;
  logic mem_ack_i = 1'b0;
  logic [31:0] mem_rdata_i = 32'h00000000;
  logic mem_req_o;
  alu_op_t mem_kind_o;
  logic [15:0] mem_addr_o;
  logic [15:0] mem_index_o;
  logic [31:0] acc_o;
  logic zero_result_flag_o;
  logic busy_o;
  logic done_o;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  alu_load_unit u_alu_load_unit (
    .clock_i(clock_i), .arst_n_i(arst_n_i), .instr_valid_i(instr_valid_i),
    .instr_op_i(instr_op_i), .operand_i(operand_i),
    .bit_count_i(bit_count_i), .out_consumed_i(out_consumed_i),
    .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
    .mem_req_o(mem_req_o), .mem_kind_o(mem_kind_o),
    .mem_addr_o(mem_addr_o), .mem_index_o(mem_index_o), .acc_o(acc_o),
    .zero_result_flag_o(zero_result_flag_o), .busy_o(busy_o),
    .done_o(done_o)
  );

  // 100 mhz clock
  initial
  begin
    forever #5 clock_i = ~clock_i;
  end

  // hang guard
  always @(posedge clock_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_errors++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d errors %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one instruction, taken while idle, one edge after the last drive
  task automatic issue(input alu_op_t op, input logic [23:0] opnd,
                       input logic [5:0] cnt);
    int i;
    @(negedge clock_i);
    for (i = 0; i < 50 && busy_o !== 1'b0; i++)
      @(negedge clock_i);
    instr_valid_i = 1'b1;
    instr_op_i = op;
    operand_i = opnd;
    bit_count_i = cnt;
    @(negedge clock_i);
    instr_valid_i = 1'b0;
  endtask

  // wait for completion, drop ack after one edge, judge result
  task automatic finish_load(input logic [31:0] exp);
    int i;
    for (i = 0; i < 20 && done_o !== 1'b1; i++)
    begin
      @(negedge clock_i);
      mem_ack_i = 1'b0;
    end
    `CHK(done_o, 1'b1)
    `CHK(acc_o, exp)
    `CHK(zero_result_flag_o, exp == 32'h0)
    `CHK(busy_o, 1'b0)
    `CHK(mem_req_o, 1'b0)
  endtask

  // memory side: check request, answer it
  task automatic serve(input alu_op_t kind, input logic [15:0] addr,
                       input logic [15:0] idx, input logic [31:0] data);
    int i;
    for (i = 0; i < 20 && mem_req_o !== 1'b1; i++)
      @(negedge clock_i);
    `CHK(mem_req_o, 1'b1)
    `CHK(busy_o, 1'b1)
    `CHK(mem_kind_o, kind)
    `CHK(mem_addr_o, addr)
    `CHK(mem_index_o, idx)
    mem_rdata_i = data;
    mem_ack_i = 1'b1;
  endtask

  task automatic t_octal();
    issue(OP_OCT_ADDR, 24'h040400, 6'h00);
    finish_load(32'h00004100);
    issue(OP_OCT_ADDR, 24'h177777, 6'h00);
    finish_load(32'h0000ffff);
    issue(OP_OCT_ADDR, 24'h000000, 6'h00);
    finish_load(32'h00000000);
  endtask

  task automatic t_indexed();
    issue(OP_OCT_ADDR, 24'h000025, 6'h00);
    finish_load(32'h00000015);
    issue(OP_IDX_WORD, 24'h000308, 6'h00);
    serve(OP_IDX_WORD, 16'h031d, 16'h0000, 32'habcd2345);
    finish_load(32'h00002345);
  endtask

  task automatic t_table();
    issue(OP_OCT_ADDR, 24'h000001, 6'h00);
    finish_load(32'h00000001);
    issue(OP_TBL_CONST, 24'h000002, 6'h00);
    serve(OP_TBL_CONST, 16'h0002, 16'h0001, 32'hffff0000);
    finish_load(32'h00000000);
  endtask

  task automatic t_format();
    issue(OP_FMT_BITS, 24'h000010, 6'h07);
    serve(OP_FMT_BITS, 16'h0010, 16'h0000, 32'haaaaaa55);
    finish_load(32'h00000055);
    issue(OP_FMT_BITS, 24'h000020, 6'h20);
    serve(OP_FMT_BITS, 16'h0020, 16'h0000, 32'h80000001);
    finish_load(32'h80000001);
    issue(OP_FMT_BITS, 24'h000030, 6'h01);
    serve(OP_FMT_BITS, 16'h0030, 16'h0000, 32'hfffffffe);
    finish_load(32'h00000000);
  endtask

  // consumed value is not pushed; offset stays the older entry
  task automatic t_consume();
    issue(OP_OCT_ADDR, 24'h000003, 6'h00);
    finish_load(32'h00000003);
    issue(OP_OCT_ADDR, 24'h000005, 6'h00);
    finish_load(32'h00000005);
    out_consumed_i = 1'b1;
    @(negedge clock_i);
    out_consumed_i = 1'b0;
    @(negedge clock_i);
    issue(OP_IDX_WORD, 24'h000100, 6'h00);
    serve(OP_IDX_WORD, 16'h0103, 16'h0000, 32'h00001234);
    finish_load(32'h00001234);
  endtask

  // main sequence
  initial
  begin
    repeat (8) @(negedge clock_i);
    arst_n_i = 1'b1;
    @(negedge clock_i);
    `CHK(acc_o, 32'h00000000)
    `CHK(zero_result_flag_o, 1'b0)
    `CHK(busy_o, 1'b0)
    t_octal();
    t_indexed();
    t_table();
    t_format();
    t_consume();
    conclude();
  end
endmodule
